// File: sim/bolc_dma_model.sv
// DMA controller model serving the transmit FIFO channel.
// Assumes the controller takes a write on the first low strobe edge.
module bolc_dma_model
(
  // Clock and enable from the bench; request from the link controller.
  input  wire logic       clk_in,
  input  wire logic       enable_in,
  input  wire logic       request_in,
  // Bus side.
  output logic            ack_n_out = 1'b1,
  output logic            wr_n_out = 1'b1,
  output logic [3:0]      index_out = 4'h0
);
  logic [1:0] step = 2'h0; // Position within one transfer.

  always @(posedge clk_in)
    if (!enable_in)
    begin
      step      <= 2'h0;
      index_out <= 4'h0;
      ack_n_out <= 1'b1;
      wr_n_out  <= 1'b1;
    end
    else
      case (step)
        2'h0:
          if (request_in)
          begin
            ack_n_out <= 1'b0;
            step      <= 2'h1;
          end
        2'h1:
        begin
          wr_n_out <= 1'b0;
          step     <= 2'h2;
        end
        2'h2:
        begin
          wr_n_out  <= 1'b1;
          ack_n_out <= 1'b1;
          index_out <= index_out + 4'h1;
          step      <= 2'h3;
        end
        default:
          step <= 2'h0;
      endcase
endmodule // bolc_dma_model

// File: sim/bolc_link_controller_props.sv
// Concurrent checks on the link controller's ports.
// Assumes it is bound to bolc_link_controller and sees only its ports.
`include "bolc_defines.vh"

module bolc_checker
(
  // Watched ports.
  input wire logic       ref_clk_in,
  input wire logic       reset_in,
  input wire logic [5:0] addr_in,
  input wire logic       cs_n_in,
  input wire logic       rd_n_in,
  input wire logic       wr_n_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_out,
  input wire logic       tx_dma_ack_n_in,
  input wire logic       rx_dma_request_out,
  input wire logic       tx_dma_request_out,
  input wire logic       link_irq_out,
  input wire logic       serial_clock_in,
  input wire logic       frame_sync_or_tx_clock_in,
  input wire logic       serial_line_oe_out,
  input wire logic [3:0] irq_enable_in,
  input wire logic       tx_length_load_in,
  input wire logic [7:0] tx_length_in
);
  logic [7:0] rem;  // Bytes the transmitter still expects.
  logic       wr_d; // Write strobe at the previous edge.
  logic [3:0] ck_h; // Recent bit clock samples.
  logic [3:0] fs_h; // Recent transmit clock samples.
  wire take = !wr_n_in && wr_d && (!tx_dma_ack_n_in || (!cs_n_in && addr_in == `BOLC_ADDR_DATA));
  wire recent = (ck_h != 4'h0 && ck_h != 4'hf) || (fs_h != 4'h0 && fs_h != 4'hf);

  // Tracks the remaining count so the request can be judged.
  always @(posedge ref_clk_in or posedge reset_in)
    if (reset_in)
    begin
      rem  <= 8'h00;
      wr_d <= 1'b1;
      ck_h <= 4'h0;
      fs_h <= 4'h0;
    end
    else
    begin
      wr_d <= wr_n_in;
      ck_h <= {ck_h[2:0], serial_clock_in};
      fs_h <= {fs_h[2:0], frame_sync_or_tx_clock_in};
      if (tx_length_load_in)
        rem <= tx_length_in;
      else if (take && rem != 8'h00)
        rem <= rem - 8'h01;
    end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_status_read;
    !cs_n_in && addr_in == `BOLC_ADDR_STATUS;
  endsequence

  property p_oe_rd; data_oe_out == (!cs_n_in && !rd_n_in); endproperty
  property p_oe_cs; cs_n_in |-> !data_oe_out; endproperty
  property p_rst_quiet;
    $fell(reset_in) |-> !rx_dma_request_out && !tx_dma_request_out && !link_irq_out;
  endproperty
  property p_irq_mask; irq_enable_in == 4'h0 |-> !link_irq_out; endproperty
  property p_line_edge; $changed(serial_line_oe_out) |-> recent; endproperty
  property p_tx_idle; rem == 8'h00 |-> !tx_dma_request_out; endproperty
  property p_tx_last; !tx_dma_ack_n_in && rem == 8'h01 |-> !tx_dma_request_out; endproperty
  property p_status_req;
    s_status_read |=> data_out[6] == $past(rx_dma_request_out);
  endproperty

  a_oe_rd: assert property (p_oe_rd) else $error("data bus enable wrong");
  a_oe_cs: assert property (p_oe_cs) else $error("bus driven while deselected");
  a_rst_quiet: assert property (p_rst_quiet) else $error("request after reset");
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
  a_line_edge: assert property (p_line_edge) else $error("line moved off clock");
  a_tx_idle: assert property (p_tx_idle) else $error("tx request with no count");
  a_tx_last: assert property (p_tx_last) else $error("tx request on last ack");
  a_status_req: assert property (p_status_req) else $error("status request bit");
endmodule // bolc_checker

// File: sim/tb_bolc_link_controller.sv
// Testbench: HDLC packets sent through local loopback and read back.
// Assumes the design header is on the include path.
`include "bolc_defines.vh"

module tb_bolc_link_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;      // Master clock.
  logic       lclk = 1'b0;     // Link bit clock.
  logic       rst = 1'b1;      // Reset.
  logic [5:0] addr = 6'h00;    // Register address.
  logic       cs_n = 1'b1;     // Chip select.
  logic       rd_n = 1'b1;     // Read strobe.
  logic       cpu_wr_n = 1'b1; // Processor write strobe.
  logic [7:0] cpu_data = 8'h00;
  logic       zero = 1'b0;     // Modes left off.
  logic [4:0] slot = 5'h00;
  logic       loop = 1'b0;
  logic       dma_en = 1'b0;
  logic [5:0] rx_th = 6'h01;
  logic [4:0] tx_th = 5'h00;
  logic       len_ld = 1'b0;
  logic [7:0] len = 8'h00;
  logic [3:0] irq_en = 4'h0;
  logic [7:0] pkt [0:7];       // Packet payload.
  wire  [7:0] dout;
  wire  [3:0] dma_idx;
  wire        ack_n, dma_wr_n, rxq, txq, irq, line_oe;
  wire        line = line_oe ? 1'b0 : 1'b1; // Pulled up when released.
  wire  [7:0] din = dma_en ? pkt[dma_idx[2:0]] : cpu_data;
  int         seed = 87, fails = 0, n_compared = 0, cyc = 0;

  always #25 clk = ~clk;
  initial
  begin
    #13;
    forever #200 lclk = ~lclk;
  end

  bolc_link_controller bolc_link_controller_inst (.ref_clk_in(clk), .reset_in(rst),
    .addr_in(addr), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(cpu_wr_n & dma_wr_n),
    .data_in(din), .data_out(dout), .data_oe_out(), .tx_dma_ack_n_in(ack_n),
    .rx_dma_request_out(rxq), .tx_dma_request_out(txq), .link_irq_out(irq),
    .serial_clock_in(lclk), .frame_sync_or_tx_clock_in(lclk), .serial_line_in(line),
    .serial_line_out(), .serial_line_oe_out(line_oe), .mux_mode_in(zero),
    .slot_select_in(slot), .local_loop_in(loop), .remote_loop_in(zero),
    .transparent_in(zero), .mode_56k_in(zero), .rx_threshold_in(rx_th),
    .tx_threshold_in(tx_th), .tx_length_load_in(len_ld), .tx_length_in(len),
    .irq_enable_in(irq_en));
  bolc_dma_model bolc_dma_model_inst (.clk_in(clk), .enable_in(dma_en), .request_in(txq),
    .ack_n_out(ack_n), .wr_n_out(dma_wr_n), .index_out(dma_idx));

  // Counts one comparison and reports a difference.
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One processor cycle; data reads pop when the strobe rises.
  task automatic acc(input logic w, input logic sel_n, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cs_n <= sel_n;
    addr <= a;
    cpu_data <= d;
    if (w)
      cpu_wr_n <= 1'b0;
    else
      rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    q = dout;
    cpu_wr_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge clk);
    cs_n <= 1'b1;
  endtask

  // Inverted reflected CRC over the payload, as the receiver stores it.
  function automatic logic [15:0] fcs_of(input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++)
      for (int b = 0; b < 8; b++)
        c = (c >> 1) ^ ((c[0] ^ pkt[i][b]) ? 16'h8408 : 16'h0000);
    return ~c;
  endfunction

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      final_report();
    end
  end

  initial
  begin
    logic [7:0] q;
    logic [15:0] c;
    int n;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 1'b0, `BOLC_ADDR_STATUS, 8'h00, q);
    chk8("status after reset", 8'h80, q);
    loop <= 1'b1;
    for (int p = 0; p < 3; p++)
    begin
      n = (p == 2) ? 1 : 2 + ($unsigned($random(seed)) % 7);
      for (int i = 0; i < n; i++)
        pkt[i] = $random(seed);
      rx_th <= 6'(n + 3);
      tx_th <= 5'($random(seed));
      irq_en <= 4'h0;
      len <= 8'(n);
      len_ld <= 1'b1;
      @(posedge clk);
      len_ld <= 1'b0;
      @(posedge clk);
      chk8("tx request after load", 8'h01, {7'h00, txq});
      if (p == 1)
      begin
        acc(1'b1, 1'b1, `BOLC_ADDR_DATA, 8'h5a, q);
        for (int i = 0; i < n; i++)
          acc(1'b1, 1'b0, `BOLC_ADDR_DATA, pkt[i], q);
      end
      else
      begin
        dma_en <= 1'b1;
        for (int t = 0; t < 1000 && dma_idx != 4'(n); t++)
          @(posedge clk);
        repeat (3) @(posedge clk);
        dma_en <= 1'b0;
      end
      @(posedge clk);
      chk8("tx request after last", 8'h00, {7'h00, txq});
      for (int t = 0; t < 4000 && rxq !== 1'b1; t++)
        @(posedge clk);
      @(posedge clk);
      chk8("rx request at end", 8'h01, {7'h00, rxq});
      chk8("masked interrupt", 8'h00, {7'h00, irq});
      irq_en <= 4'h2;
      repeat (2) @(posedge clk);
      chk8("enabled interrupt", 8'h01, {7'h00, irq});
      acc(1'b0, 1'b0, `BOLC_ADDR_STATUS, 8'h00, q);
      chk8("status at frame end", 8'hcd, q);
      @(posedge clk);
      chk8("interrupt cleared", 8'h00, {7'h00, irq});
      c = fcs_of(n);
      for (int i = 0; i < n + 2; i++)
      begin
        acc(1'b0, 1'b0, `BOLC_ADDR_STATUS, 8'h00, q);
        chk8("end mark", {7'h00, 1'(i == n + 1)}, {7'h00, q[1]});
        acc(1'b0, 1'b0, `BOLC_ADDR_DATA, 8'h00, q);
        chk8("rx byte", (i < n) ? pkt[i] : ((i == n) ? c[7:0] : c[15:8]), q);
      end
      @(posedge clk);
      chk8("rx request drained", 8'h00, {7'h00, rxq});
      $display("test packet %0d of %0d bytes done", p, n);
    end
    final_report();
  end
endmodule // tb_bolc_link_controller

bind bolc_link_controller bolc_checker bolc_checker_inst (.ref_clk_in(ref_clk_in),
  .reset_in(reset_in), .addr_in(addr_in), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in),
  .wr_n_in(wr_n_in), .data_out(data_out), .data_oe_out(data_oe_out),
  .tx_dma_ack_n_in(tx_dma_ack_n_in), .rx_dma_request_out(rx_dma_request_out),
  .tx_dma_request_out(tx_dma_request_out), .link_irq_out(link_irq_out),
  .serial_clock_in(serial_clock_in), .frame_sync_or_tx_clock_in(frame_sync_or_tx_clock_in),
  .serial_line_oe_out(serial_line_oe_out), .irq_enable_in(irq_enable_in),
  .tx_length_load_in(tx_length_load_in), .tx_length_in(tx_length_in));

// File: verilog/bolc_defines.vh
// Constants shared by the serial link controller and its FIFO.
// Assumes it is included by bare name from every design file that needs it.
`ifndef BOLC_DEFINES_VH
`define BOLC_DEFINES_VH

// Processor port register addresses.
`define BOLC_ADDR_DATA     6'h00
`define BOLC_ADDR_STATUS   6'h01

// FIFO shapes: 8 data bits plus one end-of-packet mark.
`define BOLC_FIFO_WIDTH    9
`define BOLC_RX_DEPTH      32
`define BOLC_RX_AW         5
`define BOLC_TX_DEPTH      16
`define BOLC_TX_AW         4

// Serial timing and framing.
`define BOLC_SLOT_COUNT    31
`define BOLC_MAX_RATE_KBPS 2048
`define BOLC_SLOT_RATE_KBPS 64
`define BOLC_LAST_BIT      3'h7
`define BOLC_STUFF_ONES    3'h5
`define BOLC_FLAG          8'h7e
`define BOLC_IDLE_ONES     8'hff
`define BOLC_WINDOW_FULL   4'h7
`define BOLC_CRC_INIT      16'hffff
`define BOLC_CRC_POLY      16'h8408
`define BOLC_CRC_GOOD      16'hf0b8

// Sticky status bit positions.
`define BOLC_ST_TX_DONE    0
`define BOLC_ST_RX_FRAME   1
`define BOLC_ST_FCS_ERR    2
`define BOLC_ST_RX_OVFL    3

`endif

// File: verilog/bolc_fifo.v
// Synchronous show-ahead FIFO used for the receive and transmit byte paths.
// Assumes push and pop come from logic on the same clock; DEPTH is 2**AW.
`include "bolc_defines.vh"

module bolc_fifo #(
  parameter WIDTH = `BOLC_FIFO_WIDTH,
  parameter DEPTH = `BOLC_TX_DEPTH,
  parameter AW    = `BOLC_TX_AW
) (
  // Clock and reset.
  input  wire             clk_in,
  input  wire             reset_in,
  // Fill side.
  input  wire             push_in,
  input  wire [WIDTH-1:0] data_in,
  // Drain side.
  input  wire             pop_in,
  output wire [WIDTH-1:0] data_out,
  // Level.
  output reg  [AW:0]      count_out,
  output wire             full_out,
  output wire             empty_out
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage words.
  reg [AW-1:0]    wr_ptr;           // Next word to write.
  reg [AW-1:0]    rd_ptr;           // Word shown at the output.
  wire            do_push;          // Accepted push.
  wire            do_pop;           // Accepted pop.

  assign full_out  = (count_out == DEPTH);
  assign empty_out = (count_out == {(AW+1){1'b0}});
  assign do_push   = push_in & ~full_out;
  assign do_pop    = pop_in & ~empty_out;
  assign data_out  = mem[rd_ptr];

  // Storage write; a push into a full FIFO is dropped.
  always @(posedge clk_in)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= data_in;
    end
  end

  // Pointers and level move together so full and empty stay honest.
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count_out <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_push & ~do_pop)
        count_out <= count_out + 1'b1;
      else if (do_pop & ~do_push)
        count_out <= count_out - 1'b1;
    end
  end

endmodule // bolc_fifo

// File: verilog/bolc_link_controller.v
// Bit-oriented serial link controller: serial bus port, FIFOs, DMA and processor port.
// Assumes the processor and DMA run on ref_clk_in; serial pins are asynchronous.
`include "bolc_defines.vh"

module bolc_link_controller (
  // Master clock and reset.
  input  wire       ref_clk_in,
  input  wire       reset_in,
  // Processor port.
  input  wire [5:0] addr_in,
  input  wire       cs_n_in,
  input  wire       rd_n_in,
  input  wire       wr_n_in,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output wire       data_oe_out,
  // DMA handshakes and interrupt.
  input  wire       tx_dma_ack_n_in,
  output reg        rx_dma_request_out,
  output wire       tx_dma_request_out,
  output wire       link_irq_out,
  // Serial bus port.
  input  wire       serial_clock_in,
  input  wire       frame_sync_or_tx_clock_in,
  input  wire       serial_line_in,
  output wire       serial_line_out,
  output wire       serial_line_oe_out,
  // Configuration.
  input  wire       mux_mode_in,
  input  wire [4:0] slot_select_in,
  input  wire       local_loop_in,
  input  wire       remote_loop_in,
  input  wire       transparent_in,
  input  wire       mode_56k_in,
  input  wire [5:0] rx_threshold_in,
  input  wire [4:0] tx_threshold_in,
  input  wire       tx_length_load_in,
  input  wire [7:0] tx_length_in,
  input  wire [3:0] irq_enable_in
);

  // Transmit engine states.
  localparam T_IDLE = 2'b00;
  localparam T_DATA = 2'b01;
  localparam T_FCS1 = 2'b10;
  localparam T_FCS2 = 2'b11;

  // One bit step of the reflected CRC-16 used for the FCS.
  function [15:0] bolc_crc_step;
    input [15:0] crc;
    input        bit_in;
    begin
      bolc_crc_step = (crc >> 1) ^ ((crc[0] ^ bit_in) ? `BOLC_CRC_POLY : 16'h0000);
    end
  endfunction

  // Serial pin synchronisers and edge history.
  reg [2:0] sclk_sync;        // Serial clock: two sync stages plus history.
  reg [2:0] fs_sync;          // Frame sync or transmit clock.
  reg [1:0] din_sync;         // Serial data in.
  wire      sclk_rise;        // Rising edge of the serial clock.
  wire      sclk_fall;        // Falling edge of the serial clock.
  wire      fs_fall;          // Falling edge of the transmit clock.
  wire      tx_edge;          // Transmit shift moment.
  // Slot position tracking.
  reg [7:0] rx_pos;           // Next bit position within the frame.
  reg [7:0] tx_pos;           // Transmit position in non-multiplexed mode.
  wire [7:0] rx_cur;          // Position of the bit sampled now.
  wire [7:0] tx_cur;          // Position of the bit shifted now.
  wire      rx_active;        // Sampled bit carries data in the programmed slot.
  wire      tx_slot;          // Shifted bit lies in the programmed slot.
  wire      tx_active;        // Shifted bit carries data.
  // Line and loopback.
  reg       line_bit;         // Transmitter output level.
  wire      rx_bit;           // Bit entering the receiver.
  // Transmit engine.
  reg [1:0] tx_state;         // Framing state.
  reg [7:0] tx_sh;            // Byte being shifted.
  reg [2:0] tx_cnt;           // Bits sent of this byte.
  reg [2:0] tx_ones;          // Consecutive ones sent.
  reg [15:0] tx_crc;          // Running transmit FCS.
  reg [7:0] tx_fcs_hi;        // Second FCS byte.
  reg       tx_eop_cur;       // Byte in shifter closes the packet.
  reg       tx_pop;           // Take the FIFO head.
  wire [15:0] tx_crc_n;       // FCS after this bit.
  // Receive engine.
  reg [7:0] rx_hist;          // Raw window for flag detection.
  reg [3:0] rx_hcnt;          // Valid bits in the window.
  reg [2:0] rx_ones;          // Ones in the destuffed stream.
  reg [7:0] rx_sh;            // Byte being assembled.
  reg [2:0] rx_cnt;           // Bits assembled.
  reg [15:0] rx_crc;          // Running receive FCS.
  reg [7:0] rx_pend;          // Last complete byte awaiting its mark.
  reg       rx_pend_v;        // Pending byte valid.
  reg       rx_push;          // Write to receive FIFO.
  reg [8:0] rx_push_data;     // Word written, mark in bit 8.
  reg [3:0] sticky_set;       // Events seen this cycle.
  wire [7:0] rx_hist_n;       // Window after this bit.
  wire      rx_out_bit;       // Bit leaving the window.
  // FIFO connections.
  wire [8:0] rx_head;         // Receive FIFO head.
  wire [5:0] rx_count;        // Receive FIFO level.
  wire      rx_full;          // Receive FIFO full.
  wire      rx_empty;         // Receive FIFO empty.
  wire [8:0] tx_head;         // Transmit FIFO head.
  wire [4:0] tx_count;        // Transmit FIFO level.
  wire      tx_full;          // Transmit FIFO full.
  wire      tx_empty;         // Transmit FIFO empty.
  // Processor port.
  reg       wr_prev;          // Write strobe one cycle ago.
  reg       rd_prev;          // Read strobe one cycle ago.
  reg [1:0] rd_kind;          // Read in progress: bit0 data, bit1 status.
  reg [7:0] tx_remaining;     // Bytes still to be loaded this packet.
  reg [3:0] sticky;           // Latched status events.
  wire      sel;              // Chip selected.
  wire      rd_end;           // Read strobe just released.
  wire      tx_push;          // Byte written to the transmit FIFO.
  wire      rx_pop;           // Byte read from the receive FIFO.
  wire      status_clear;     // Status read completed.
  wire [7:0] status;          // Status register image.

  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sclk_sync <= 3'h0;
      fs_sync   <= 3'h0;
      din_sync  <= 2'h3;
    end
    else
    begin
      sclk_sync <= {sclk_sync[1:0], serial_clock_in};
      fs_sync   <= {fs_sync[1:0], frame_sync_or_tx_clock_in};
      din_sync  <= {din_sync[0], serial_line_in};
    end
  end

  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  assign fs_fall   = ~fs_sync[1] & fs_sync[2];
  assign tx_edge   = mux_mode_in ? sclk_fall : fs_fall;

  assign rx_cur    = (mux_mode_in & fs_sync[1]) ? 8'h00 : rx_pos;
  assign tx_cur    = mux_mode_in ? rx_pos : tx_pos;
  assign rx_active = (~mux_mode_in | (rx_cur[7:3] == slot_select_in))
                     & ~(mode_56k_in & (rx_cur[2:0] == `BOLC_LAST_BIT));
  assign tx_slot   = ~mux_mode_in | (tx_cur[7:3] == slot_select_in);
  assign tx_active = tx_slot & ~(mode_56k_in & (tx_cur[2:0] == `BOLC_LAST_BIT));

  // Bit position counters advance on their own clock edges.
  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_pos <= 8'h00;
      tx_pos <= 8'h00;
    end
    else
    begin
      if (sclk_rise)
        rx_pos <= rx_cur + 8'h01;
      if (tx_edge & ~mux_mode_in)
        tx_pos <= tx_pos + 8'h01;
    end
  end

  assign rx_bit   = local_loop_in ? line_bit : din_sync[1];
  // Open-drain line: only a low is driven.
  assign serial_line_out    = 1'b0;
  assign serial_line_oe_out = ~line_bit;
  assign tx_crc_n = bolc_crc_step(tx_crc, tx_sh[0]);

  // Transmit engine: one bit per transmit edge, LSB first.
  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      line_bit   <= 1'b1;
      tx_state   <= T_IDLE;
      tx_sh      <= `BOLC_FLAG;
      tx_cnt     <= 3'h0;
      tx_ones    <= 3'h0;
      tx_crc     <= `BOLC_CRC_INIT;
      tx_fcs_hi  <= 8'h00;
      tx_eop_cur <= 1'b0;
      tx_pop     <= 1'b0;
    end
    else
    begin
      tx_pop <= 1'b0;
      if (tx_edge)
      begin
        if (remote_loop_in)
        begin
          line_bit <= din_sync[1];
        end
        else if (~tx_active)
        begin
          line_bit <= 1'b1;
        end
        else if ((tx_state != T_IDLE) & ~transparent_in & (tx_ones == `BOLC_STUFF_ONES))
        begin
          line_bit <= 1'b0;
          tx_ones  <= 3'h0;
        end
        else
        begin
          line_bit <= tx_sh[0];
          tx_sh    <= {1'b1, tx_sh[7:1]};
          tx_cnt   <= tx_cnt + 3'h1;
          tx_ones  <= (tx_sh[0] & (tx_state != T_IDLE)) ? tx_ones + 3'h1 : 3'h0;
          if (tx_state == T_DATA)
            tx_crc <= tx_crc_n;
          if (tx_cnt == `BOLC_LAST_BIT)
          begin
            case (tx_state)
              T_FCS1:
              begin
                tx_sh    <= tx_fcs_hi;
                tx_state <= T_FCS2;
              end
              T_FCS2:
              begin
                tx_sh    <= `BOLC_FLAG;
                tx_state <= T_IDLE;
              end
              default:
              begin
                if ((tx_state == T_DATA) & ~transparent_in & (tx_eop_cur | tx_empty))
                begin
                  tx_sh     <= ~tx_crc_n[7:0];
                  tx_fcs_hi <= ~tx_crc_n[15:8];
                  tx_state  <= T_FCS1;
                end
                else if (~tx_empty)
                begin
                  tx_sh      <= tx_head[7:0];
                  tx_eop_cur <= tx_head[8];
                  tx_pop     <= 1'b1;
                  tx_state   <= T_DATA;
                  if (tx_state == T_IDLE)
                    tx_crc <= `BOLC_CRC_INIT;
                end
                else
                begin
                  tx_sh    <= transparent_in ? `BOLC_IDLE_ONES : `BOLC_FLAG;
                  tx_state <= T_IDLE;
                end
              end
            endcase
          end
        end
      end
    end
  end

  assign rx_hist_n  = {rx_bit, rx_hist[7:1]};
  assign rx_out_bit = rx_hist[1];

  // Receive engine: one bit per rising serial clock in the programmed slot.
  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_hist      <= 8'h00;
      rx_hcnt      <= 4'h0;
      rx_ones      <= 3'h0;
      rx_sh        <= 8'h00;
      rx_cnt       <= 3'h0;
      rx_crc       <= `BOLC_CRC_INIT;
      rx_pend      <= 8'h00;
      rx_pend_v    <= 1'b0;
      rx_push      <= 1'b0;
      rx_push_data <= 9'h000;
      sticky_set   <= 4'h0;
    end
    else
    begin
      rx_push    <= 1'b0;
      sticky_set <= {rx_push & rx_full, 1'b0, 1'b0, tx_state == T_FCS2 & tx_edge
                     & (tx_cnt == `BOLC_LAST_BIT) & ~remote_loop_in & tx_active};
      if (sclk_rise & rx_active)
      begin
        if (transparent_in)
        begin
          rx_sh  <= {rx_bit, rx_sh[7:1]};
          rx_cnt <= rx_cnt + 3'h1;
          if (rx_cnt == `BOLC_LAST_BIT)
          begin
            rx_push      <= 1'b1;
            rx_push_data <= {1'b0, rx_bit, rx_sh[7:1]};
          end
        end
        else if (rx_hist_n == `BOLC_FLAG)
        begin
          if (rx_pend_v)
          begin
            rx_push       <= 1'b1;
            rx_push_data  <= {1'b1, rx_pend};
            sticky_set[`BOLC_ST_RX_FRAME] <= 1'b1;
            sticky_set[`BOLC_ST_FCS_ERR]  <= (rx_crc != `BOLC_CRC_GOOD);
          end
          rx_hcnt   <= 4'h0;
          rx_cnt    <= 3'h0;
          rx_ones   <= 3'h0;
          rx_pend_v <= 1'b0;
          rx_crc    <= `BOLC_CRC_INIT;
          rx_hist   <= rx_hist_n;
        end
        else
        begin
          rx_hist <= rx_hist_n;
          if (rx_hcnt != `BOLC_WINDOW_FULL)
            rx_hcnt <= rx_hcnt + 4'h1;
          else if (~rx_out_bit & (rx_ones == `BOLC_STUFF_ONES))
            rx_ones <= 3'h0;
          else
          begin
            rx_ones <= rx_out_bit ? rx_ones + {2'b00, rx_ones != 3'h7} : 3'h0;
            rx_sh   <= {rx_out_bit, rx_sh[7:1]};
            rx_crc  <= bolc_crc_step(rx_crc, rx_out_bit);
            rx_cnt  <= rx_cnt + 3'h1;
            if (rx_cnt == `BOLC_LAST_BIT)
            begin
              rx_pend   <= {rx_out_bit, rx_sh[7:1]};
              rx_pend_v <= 1'b1;
              if (rx_pend_v)
              begin
                rx_push      <= 1'b1;
                rx_push_data <= {1'b0, rx_pend};
              end
            end
          end
        end
      end
    end
  end

  bolc_fifo #(
    .WIDTH (`BOLC_FIFO_WIDTH),
    .DEPTH (`BOLC_RX_DEPTH),
    .AW    (`BOLC_RX_AW)
  ) u_rx_fifo (
    .clk_in    (ref_clk_in),
    .reset_in  (reset_in),
    .push_in   (rx_push),
    .data_in   (rx_push_data),
    .pop_in    (rx_pop),
    .data_out  (rx_head),
    .count_out (rx_count),
    .full_out  (rx_full),
    .empty_out (rx_empty)
  );

  bolc_fifo #(
    .WIDTH (`BOLC_FIFO_WIDTH),
    .DEPTH (`BOLC_TX_DEPTH),
    .AW    (`BOLC_TX_AW)
  ) u_tx_fifo (
    .clk_in    (ref_clk_in),
    .reset_in  (reset_in),
    .push_in   (tx_push),
    .data_in   ({tx_remaining == 8'h01, data_in}),
    .pop_in    (tx_pop),
    .data_out  (tx_head),
    .count_out (tx_count),
    .full_out  (tx_full),
    .empty_out (tx_empty)
  );

  assign sel          = ~cs_n_in;
  assign data_oe_out  = sel & ~rd_n_in;
  assign rd_end       = rd_n_in & rd_prev;
  assign tx_push      = ~wr_n_in & wr_prev
                        & ((sel & (addr_in == `BOLC_ADDR_DATA)) | ~tx_dma_ack_n_in);
  assign rx_pop       = rd_end & rd_kind[0];
  assign status_clear = rd_end & rd_kind[1];
  assign status = {tx_empty, rx_dma_request_out, sticky, rx_head[8], ~rx_empty};

  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_prev      <= 1'b1;
      rd_prev      <= 1'b0;
      rd_kind      <= 2'b00;
      data_out     <= 8'h00;
      tx_remaining <= 8'h00;
    end
    else
    begin
      wr_prev  <= wr_n_in;
      rd_prev  <= sel & ~rd_n_in;
      rd_kind  <= {sel & ~rd_n_in & (addr_in == `BOLC_ADDR_STATUS),
                   sel & ~rd_n_in & (addr_in == `BOLC_ADDR_DATA)};
      data_out <= (addr_in == `BOLC_ADDR_STATUS) ? status : rx_head[7:0];
      if (tx_length_load_in)
        tx_remaining <= tx_length_in;
      else if (tx_push & ~tx_full & (tx_remaining != 8'h00))
        tx_remaining <= tx_remaining - 8'h01;
    end
  end

  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      sticky <= 4'h0;
    else
      sticky <= (sticky & ~{4{status_clear}}) | sticky_set;
  end
  assign link_irq_out = |(sticky & irq_enable_in);

  always @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      rx_dma_request_out <= 1'b0;
    else if (rx_pop & rx_head[8])
      rx_dma_request_out <= 1'b0;
    else if (rx_push & ~rx_full
             & ((rx_count + 6'h01 == rx_threshold_in) | rx_push_data[8]))
      rx_dma_request_out <= 1'b1;
    else if (rx_empty)
      rx_dma_request_out <= 1'b0;
  end

  assign tx_dma_request_out = (tx_remaining != 8'h00) & ~tx_full
                              & (tx_count <= tx_threshold_in)
                              & ~(~tx_dma_ack_n_in & (tx_remaining == 8'h01));

endmodule // bolc_link_controller
